// File: common/brcfg_pkg.sv
// Purpose: Constants for the board reset configuration register file
// Assumes: Word index is taken from byte address bits 4:2
// Notes:   Field positions count from bit 0, the most significant data line
package brcfg_pkg;
    // Word indexes (byte offset / 4)
    localparam logic [2:0]  IDX_HRC     = 3'h0;
    localparam logic [2:0]  IDX_BC1     = 3'h1;
    localparam logic [2:0]  IDX_UNLOCK  = 3'h3;
    // Field positions in the configuration word
    localparam int          F_ARB       = 0;
    localparam int          F_PREFIX    = 1;
    localparam int          F_RSV2      = 2;
    localparam int          F_BOOT_INH  = 3;
    localparam int          F_BOOT_W    = 4;
    localparam int          F_RSV6      = 6;
    localparam int          F_MAP_BASE  = 7;
    localparam int          F_DBG_PIN   = 9;
    localparam int          F_DBG_PORT  = 11;
    localparam int          F_CLK_DIV   = 13;
    localparam int          F_RSV15     = 15;
    // Control bits in board_control_one
    localparam int          B_FLASH_CFG_N = 5;
    localparam int          B_DISABLE   = 7;
    // Bit of the unlock register holding the disable_unlock_bit
    localparam int          B_UNLOCK    = 0;
    // Power-on values
    localparam logic [15:0] HRC_RESET   = 16'h0680;
    localparam logic [15:0] BC1_RESET   = 16'h0020;
    localparam logic [15:0] ZERO16      = 16'h0000;
endpackage

// File: rtl/brcfg_regs.sv
// Purpose: Board register file holding the hard reset configuration word
// Assumes: Host bus shares i_clock; i_resetn is the power-on reset
// Notes:   Register bit k appears on data line 31-k; lines 15:0 read zero
`timescale 1ns/1ns
`default_nettype none
module brcfg_regs (
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_sel,
    input  wire logic        i_wr,
    input  wire logic [4:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_hard_reset,
    output logic             o_ack,
    output logic      [31:0] o_rdata,
    output logic             o_cfg_drive,
    output logic      [31:0] o_cfg_bus,
    output logic      [15:0] o_board_control_one,
    output logic             o_disabled
);
    // All state of the block
    typedef struct packed {
        logic [15:0] hrc;      // Hard reset configuration fields
        logic [15:0] bc1;      // Board control one fields
        logic        unlock;   // Disable bit may change once
        logic        ack;      // Access answer
        logic [31:0] rdata;    // Read data
        logic        drive;    // Configuration word on the bus
        logic [31:0] cfg;      // Configuration word image
    } brcfg_state_t;

    brcfg_state_t st_r;        // Registered state
    brcfg_state_t st_nxt;      // Next state

    // Field vector to bus word: bit k on line 31-k, low lines zero
    function automatic logic [31:0] brcfg_word(input logic [15:0] f);
        logic [31:0] w;
        w = {brcfg_pkg::ZERO16, brcfg_pkg::ZERO16};
        for (int k = 0; k < 16; k++) begin
            w[31-k] = f[k];
        end
        return w;
    endfunction

    // Bus word to field vector, upper data lines only
    function automatic logic [15:0] brcfg_field(input logic [31:0] w);
        logic [15:0] f;
        f = brcfg_pkg::ZERO16;
        for (int k = 0; k < 16; k++) begin
            f[k] = w[31-k];
        end
        return f;
    endfunction

    logic       access;        // Request taken this cycle
    logic [2:0] idx;           // Word index
    logic [15:0] wf;           // Written fields

    assign idx    = i_addr[4:2];
    assign wf     = brcfg_field(i_wdata);
    assign access = i_sel && !st_r.bc1[brcfg_pkg::B_DISABLE];

    // Next state
    always_comb begin
        st_nxt     = st_r;
        st_nxt.ack = access;
        if (access && i_wr) begin
            case (idx)
                brcfg_pkg::IDX_HRC: begin
                    // Every field incl. reserved bits is plain storage
                    st_nxt.hrc = wf;
                end
                brcfg_pkg::IDX_BC1: begin
                    st_nxt.bc1 = wf;
                    // Disable bit only moves when unlocked
                    if (!st_r.unlock) begin
                        st_nxt.bc1[brcfg_pkg::B_DISABLE] =
                            st_r.bc1[brcfg_pkg::B_DISABLE];
                    end
                    st_nxt.unlock = 1'b0;
                end
                brcfg_pkg::IDX_UNLOCK: begin
                    // Writing 1 unlocks the disable bit
                    if (wf[brcfg_pkg::B_UNLOCK]) begin
                        st_nxt.unlock = 1'b1;
                    end
                end
                default: begin
                    // Unmapped write is acknowledged and dropped
                end
            endcase
        end
        // Read data
        case (idx)
            brcfg_pkg::IDX_HRC:    st_nxt.rdata = brcfg_word(st_r.hrc);
            brcfg_pkg::IDX_BC1:    st_nxt.rdata = brcfg_word(st_r.bc1);
            brcfg_pkg::IDX_UNLOCK: st_nxt.rdata = brcfg_word({15'h0000, st_r.unlock});
            default:               st_nxt.rdata = {brcfg_pkg::ZERO16, brcfg_pkg::ZERO16};
        endcase
        if (!access || i_wr) begin
            st_nxt.rdata = {brcfg_pkg::ZERO16, brcfg_pkg::ZERO16};
        end
        // Hard reset: present stored word unless flash supplies it
        st_nxt.drive = i_hard_reset && st_r.bc1[brcfg_pkg::B_FLASH_CFG_N];
        st_nxt.cfg   = st_nxt.drive ? brcfg_word(st_r.hrc)
                                    : {brcfg_pkg::ZERO16, brcfg_pkg::ZERO16};
    end

    // State register, power-on defaults
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            st_r        <= '0;
            st_r.hrc    <= brcfg_pkg::HRC_RESET;
            st_r.bc1    <= brcfg_pkg::BC1_RESET;
        end else begin
            st_r        <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign o_ack               = st_r.ack;
    assign o_rdata             = st_r.rdata;
    assign o_cfg_drive         = st_r.drive;
    assign o_cfg_bus           = st_r.cfg;
    assign o_board_control_one = st_r.bc1;
    assign o_disabled          = st_r.bc1[brcfg_pkg::B_DISABLE];

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    property p_arb;
        o_cfg_drive && $stable(st_r.hrc) |-> o_cfg_bus[31] == st_r.hrc[brcfg_pkg::F_ARB];
    endproperty
    a_arb: assert property (p_arb) else $error("arb line wrong");
    property p_prefix;
        o_cfg_drive && $stable(st_r.hrc) |-> o_cfg_bus[30] == st_r.hrc[brcfg_pkg::F_PREFIX];
    endproperty
    a_prefix: assert property (p_prefix) else $error("prefix line wrong");
    property p_boot;
        o_cfg_drive && $stable(st_r.hrc) |-> o_cfg_bus[28:26] == {st_r.hrc[3], st_r.hrc[4],
            st_r.hrc[5]};
    endproperty
    a_boot: assert property (p_boot) else $error("boot lines wrong");
    // Map base lines follow the stored word while driven
    property p_map;
        o_cfg_drive && $stable(st_r.hrc) |-> o_cfg_bus[24:23] ==
            {st_r.hrc[brcfg_pkg::F_MAP_BASE], st_r.hrc[brcfg_pkg::F_MAP_BASE+1]};
    endproperty
    a_map: assert property (p_map) else $error("map base lines wrong");
    // Debug and clock divider lines, bit 9 on line 22 down to bit 14 on line 17
    property p_dbg;
        o_cfg_drive && $stable(st_r.hrc) |-> o_cfg_bus[22:17] == {st_r.hrc[9], st_r.hrc[10],
            st_r.hrc[11], st_r.hrc[12], st_r.hrc[13], st_r.hrc[14]};
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug lines wrong");
    property p_dflt;
        $rose(i_resetn) |-> st_r.hrc[8:7] == 2'h1 && st_r.hrc[10:9] == 2'h3
            && st_r.hrc[14:11] == 4'h0;
    endproperty
    a_dflt: assert property (p_dflt) else $error("field defaults wrong");
    property p_rsv;
        i_sel && i_wr && idx == brcfg_pkg::IDX_HRC && !o_disabled |=> st_r.hrc[2] == $past(i_wdata[29])
            && st_r.hrc[15] == $past(i_wdata[16]);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit not stored");
    property p_off;
        o_disabled |=> !o_ack ##1 !o_ack;
    endproperty
    a_off: assert property (p_off) else $error("access while disabled");
    // Read of control register one returns the word held at the taking edge
    property p_rd1;
        i_sel && !i_wr && idx == brcfg_pkg::IDX_BC1 && !o_disabled |=> o_ack
            && o_rdata == brcfg_word($past(st_r.bc1));
    endproperty
    a_rd1: assert property (p_rd1) else $error("bc1 read wrong");
    property p_por;
        $rose(i_resetn) |-> o_board_control_one == brcfg_pkg::BC1_RESET;
    endproperty
    a_por: assert property (p_por) else $error("bc1 default wrong");
    property p_lock;
        !st_r.unlock && i_sel && i_wr && idx == brcfg_pkg::IDX_BC1 |=> $stable(o_disabled);
    endproperty
    a_lock: assert property (p_lock) else $error("locked bit changed");
    property p_drive;
        i_hard_reset && o_board_control_one[brcfg_pkg::B_FLASH_CFG_N] |=> o_cfg_drive;
    endproperty
    a_drive: assert property (p_drive) else $error("config not driven");
    // Idle configuration bus shows zero
    property p_cfg_idle;
        !o_cfg_drive |-> o_cfg_bus == 32'h0000_0000;
    endproperty
    a_cfg_idle: assert property (p_cfg_idle) else $error("config bus not idle");
    property p_relock;
        i_sel && i_wr && idx == brcfg_pkg::IDX_BC1 && !o_disabled |=> !st_r.unlock;
    endproperty
    a_relock: assert property (p_relock) else $error("not relocked");
    property p_low;
        o_ack |-> o_rdata[15:0] == 16'h0000 && (o_cfg_bus[15:0] == 16'h0000);
    endproperty
    a_low: assert property (p_low) else $error("low lines not zero");

    c_drive:   cover property (i_hard_reset ##1 o_cfg_drive);
    c_disable: cover property (st_r.unlock ##[1:20] o_disabled);
    c_rd_hrc:  cover property (i_sel && !i_wr && idx == brcfg_pkg::IDX_HRC ##1 o_ack);
    // Hard reset while flash supplies the word
    c_flash:   cover property (i_hard_reset && !o_board_control_one[brcfg_pkg::B_FLASH_CFG_N]);
endmodule
`default_nettype wire

// File: sim/brcfg_host_model.sv
// Purpose: Host bus model making single word accesses
// Assumes: Each access starts at a falling clock edge
// Notes:   Released address and data lines show the inverse of the last value; o_wr keeps it
`timescale 1ns/1ns
`default_nettype none
module brcfg_host_model (
    input  wire logic        i_clock,
    input  wire logic        i_ack,
    input  wire logic [31:0] i_rdata,
    output logic             o_sel,
    output logic             o_wr,
    output logic      [4:0]  o_addr,
    output logic      [31:0] o_wdata
);
    // Bus idle at time zero
    initial begin
        o_sel = 1'b0;
        o_wr = 1'b0;
        o_addr = 5'h1F;
        o_wdata = 32'hFFFF_FFFF;
    end
    // Request stands for one taking edge; answer read in the ack cycle
    task automatic xfer(input logic wr, input logic [4:0] addr, input logic [31:0] wdata,
                        output logic ack, output logic [31:0] rdata);
        o_sel = 1'b1;
        o_wr = wr;
        o_addr = addr;
        o_wdata = wdata;
        @(negedge i_clock);
        ack = i_ack;
        rdata = i_rdata;
        o_sel = 1'b0;
        o_addr = ~addr;
        o_wdata = ~wdata;
        @(negedge i_clock);
    endtask
endmodule
`default_nettype wire

// File: sim/brcfg_tb.sv
// Purpose: Self-checking bench for the board register file
// Assumes: Inputs change on the falling clock edge
// Notes:   Expected words are built from the field layout
`timescale 1ns/1ns
`default_nettype none
module board_reset_config_register_tb_top;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        hard_reset = 1'b0;
    logic        sel, wr, ack, drive, dis;
    logic [4:0]  addr;
    logic [31:0] wdata, rdata, cfg;
    logic [15:0] bc1;
    int          mismatches = 0;
    int          check_count = 0;
    // 250 MHz clock
    always #2 clock = ~clock;
    brcfg_host_model i_brcfg_host_model (.i_clock(clock), .i_ack(ack), .i_rdata(rdata),
        .o_sel(sel), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
    brcfg_regs i_brcfg_regs (.i_clock(clock), .i_resetn(resetn), .i_sel(sel), .i_wr(wr),
        .i_addr(addr), .i_wdata(wdata), .i_hard_reset(hard_reset), .o_ack(ack),
        .o_rdata(rdata), .o_cfg_drive(drive), .o_cfg_bus(cfg),
        .o_board_control_one(bc1), .o_disabled(dis));
    // Field k of a register sits on data line 31-k
    function automatic logic [31:0] ln(input logic [15:0] v);
        for (int k = 0; k < 16; k++) ln[31-k] = v[k];
        ln[15:0] = 16'h0000;
    endfunction
    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One access with its expected answer
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic ea, input logic [31:0] er);
        logic        k;
        logic [31:0] r;
        i_brcfg_host_model.xfer(w, a, d, k, r);
        chk("ack", {31'h0, k}, {31'h0, ea});
        if (!w) chk("rdata", r, er);
    endtask
    // Hold hard reset for n cycles and check the drive
    task automatic hr(input int n, input logic ed, input logic [31:0] ew);
        hard_reset = 1'b1;
        repeat (n) @(negedge clock);
        chk("drive", {31'h0, drive}, {31'h0, ed});
        chk("cfg_bus", cfg, ew);
        hard_reset = 1'b0;
        @(negedge clock);
        chk("drive_off", {31'h0, drive}, 32'h0000_0000);
        chk("cfg_off", cfg, 32'h0000_0000);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Power-on values and map
    task automatic t_reset;
        acc(1'b0, 5'h00, 32'h0, 1'b1, ln(16'h0680));
        chk("bc1", {16'h0, bc1}, 32'h0000_0020);
        acc(1'b0, 5'h04, 32'h0, 1'b1, ln(16'h0020));
        acc(1'b0, 5'h0C, 32'h0, 1'b1, 32'h0000_0000);
        acc(1'b1, 5'h08, 32'hFFFF_0000, 1'b1, 32'h0);
        acc(1'b0, 5'h08, 32'h0, 1'b1, 32'h0000_0000);
        $display("test reset done");
    endtask
    // Every bit both ways, upper half only; then driven in hard reset
    task automatic t_word;
        acc(1'b1, 5'h00, 32'hA5C3_FFFF, 1'b1, 32'h0);
        acc(1'b0, 5'h00, 32'h0, 1'b1, 32'hA5C3_0000);
        hr(3, 1'b1, 32'hA5C3_0000);
        acc(1'b1, 5'h00, 32'h5A3C_1234, 1'b1, 32'h0);
        acc(1'b0, 5'h00, 32'h0, 1'b1, 32'h5A3C_0000);
        hr(1, 1'b1, 32'h5A3C_0000);
        $display("test word done");
    endtask
    // Flash source active: no drive
    task automatic t_flash;
        acc(1'b1, 5'h04, 32'h0, 1'b1, 32'h0);
        chk("bc1", {16'h0, bc1}, 32'h0000_0000);
        hr(2, 1'b0, 32'h0000_0000);
        acc(1'b1, 5'h04, ln(16'h0020), 1'b1, 32'h0);
        $display("test flash done");
    endtask
    // Protected disable, relock, then real disable
    task automatic t_dis;
        acc(1'b1, 5'h04, ln(16'h00A0), 1'b1, 32'h0);
        chk("locked", {dis, 15'h0, bc1}, 32'h0000_0020);
        acc(1'b1, 5'h0C, 32'h8000_0000, 1'b1, 32'h0);
        acc(1'b0, 5'h0C, 32'h0, 1'b1, 32'h8000_0000);
        acc(1'b1, 5'h04, ln(16'h0020), 1'b1, 32'h0);
        acc(1'b1, 5'h04, ln(16'h00A0), 1'b1, 32'h0);
        chk("relocked", {dis, 15'h0, bc1}, 32'h0000_0020);
        acc(1'b1, 5'h0C, 32'h8000_0000, 1'b1, 32'h0);
        acc(1'b1, 5'h04, ln(16'h00A0), 1'b1, 32'h0);
        chk("disabled", {dis, 15'h0, bc1}, 32'h8000_00A0);
        acc(1'b0, 5'h00, 32'h0, 1'b0, 32'h0);
        $display("test disable done");
    endtask
    // Main sequence
    initial begin
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        t_reset();
        t_word();
        t_flash();
        t_dis();
        wrap_up();
    end
    // Watchdog
    initial begin
        #20000;
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
